// ===== logic/tic_top.sv
// input capture and difference capture timer with a wishbone slave
// assumes a classic wishbone master and a capture pin synchronous to mclk
// Operation
// - capture mode decrements the count every clock at once, no start command
// - selected pin edge copies the count into the capture/reload register
// - interrupt request only while mask bit and global enable are both set
// - capture modes keep capture pending and underflow pending flags
// - interrupt requested as a level for as long as a pending flag stays set
// - capture and underflow in one cycle set both flags
// - in capture modes the run bit never starts or stops the counter
// - edge select bit picks rising or falling pin transitions
// - edge select change applies to later edges without leaving the mode
// - difference mode offers four first-to-second edge pairings
// - after first edge an up-counter steps once per clock
// - second edge stops the up-counter and stores elapsed count
// - difference mode sets both pending flags like capture mode
// - capture pending flag sits at bit 3 of the control register
// - outside capture modes the run bit starts and stops the timer
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tic_map.svh"

module tic_top
	import tic_pkg::*;
(
	input  wire logic        mclk,                    // 100 MHz clock
	input  wire logic        rst_n,                   // async reset, low
	input  wire logic        wb_cyc_i,                // bus cycle
	input  wire logic        wb_stb_i,                // bus strobe
	input  wire logic        wb_we_i,                 // write enable
	input  wire logic [3:0]  wb_sel_i,                // byte lanes
	input  wire logic [7:0]  wb_adr_i,                // byte address
	input  wire logic [31:0] wb_dat_i,                // write data
	input  wire logic        capture_input_pin,       // measured signal
	output logic             wb_ack_o,                // bus acknowledge
	output logic      [31:0] wb_dat_o,                // read data
	output logic             timer_interrupt_request  // request to core
);

	logic        rst_q1;
	logic        rst_s_n;
	tic_ctrl_s   ctrl;
	logic [15:0] count_register;
	logic [15:0] capture_reload_register;
	logic        global_int_en;
	tic_diff_e   dstate;
	logic        rise;
	logic        fall;

	// reset release through two flip-flops
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_q1  <= 1'b0;
			rst_s_n <= 1'b0;
		end
		else
		begin
			rst_q1  <= 1'b1;
			rst_s_n <= rst_q1;
		end
	end

	tic_edge u_edge (
		.mclk    (mclk),
		.rst_s_n (rst_s_n),
		.pin     (capture_input_pin),
		.rise    (rise),
		.fall    (fall)
	);

	// bus decode; a write lands on the edge where ack is sampled
	wire       req     = wb_cyc_i & wb_stb_i;
	wire [7:0] adr_w   = {wb_adr_i[7:2], 2'b00};
	wire       hit_ctl = adr_w == `TIC_OFS_CTRL;
	wire       hit_cnt = adr_w == `TIC_OFS_COUNT;
	wire       hit_cap = adr_w == `TIC_OFS_CAPT;
	wire       hit_cor = adr_w == `TIC_OFS_CORE;
	wire       wr_go   = req & wb_we_i & wb_ack_o;
	wire       wr_ctrl = wr_go & hit_ctl & wb_sel_i[0];
	wire       wr_gie  = wr_go & hit_cor & wb_sel_i[0];
	wire       wr_cnt  = wr_go & hit_cnt & (|wb_sel_i[1:0]);
	wire       wr_cap  = wr_go & hit_cap & (|wb_sel_i[1:0]);

	// byte-lane merge of 16-bit writes
	wire [15:0] cnt_wdat = {wb_sel_i[1] ? wb_dat_i[15:8] : count_register[15:8],
		wb_sel_i[0] ? wb_dat_i[7:0] : count_register[7:0]};
	wire [15:0] cap_wdat = {wb_sel_i[1] ? wb_dat_i[15:8]
		: capture_reload_register[15:8],
		wb_sel_i[0] ? wb_dat_i[7:0] : capture_reload_register[7:0]};
	wire tic_ctrl_s ctrl_wdat = tic_ctrl_s'(wb_dat_i[`TIC_CTRL_W-1:0]);

	// mode decode
	wire in_capt  = ctrl.mode == TIC_MODE_CAPT;
	wire in_diff  = ctrl.mode == TIC_MODE_DIFF;
	wire in_pwm   = ctrl.mode == TIC_MODE_PWM;
	wire in_event = ctrl.mode == TIC_MODE_EVENT;

	// edge selection, polarity read live each cycle
	wire cap_edge = ctrl.edge1 ? fall : rise;
	wire sec_edge = ctrl.edge2 ? fall : rise;
	wire first_go = in_diff & (dstate == TIC_ARM) & cap_edge;
	wire diff_run = in_diff & (dstate == TIC_RUN);
	wire sec_go   = diff_run & sec_edge;

	// events: capture, wrap of down or up count, reload underflow
	wire at_zero  = count_register == `TIC_ZERO;
	wire dn_uf    = in_capt & at_zero;
	wire up_uf    = diff_run & ~sec_edge
		& (count_register == `TIC_ALL_ONES);
	wire rl_step  = (in_pwm & ctrl.run)
		| (in_event & ctrl.run & cap_edge);
	wire rl_uf    = rl_step & at_zero;
	wire capt_ev  = (in_capt & cap_edge) | sec_go;
	wire uf_ev    = dn_uf | up_uf;
	wire pnd_ev   = capt_ev | rl_uf;

	// next count value; a software load wins over counting
	logic [15:0] next_count;
	always_comb
	begin
		next_count = count_register;
		if (wr_cnt)
			next_count = cnt_wdat;
		else if (in_capt)
			next_count = 16'(count_register - `TIC_ONE);
		else if (first_go)
			next_count = `TIC_ZERO;
		else if (diff_run & ~sec_edge)
			next_count = 16'(count_register + `TIC_ONE);
		else if (rl_uf)
			next_count = capture_reload_register;
		else if (rl_step)
			next_count = 16'(count_register - `TIC_ONE);
	end

	// next control value; hardware setting a flag beats a clear
	tic_ctrl_s next_ctrl;
	always_comb
	begin
		next_ctrl = wr_ctrl ? ctrl_wdat : ctrl;
		next_ctrl.pnd = next_ctrl.pnd | pnd_ev;
		next_ctrl.run = next_ctrl.run | uf_ev;
	end

	// difference sequencer: wait first edge, count, stop on second
	tic_diff_e next_dstate;
	always_comb
	begin
		next_dstate = dstate;
		if (!in_diff)
			next_dstate = TIC_ARM;
		else if (first_go)
			next_dstate = TIC_RUN;
		else if (sec_go)
			next_dstate = TIC_ARM;
	end

	// interrupt level, gated by mask and global enable
	wire flag_any = ctrl.pnd | ((in_capt | in_diff) & ctrl.run);
	wire next_irq = ctrl.mask & global_int_en & flag_any;

	// read mux, unmapped offsets read zero
	wire [31:0] rd_ctl = {{(32-`TIC_CTRL_W){1'b0}}, ctrl};
	wire [31:0] rd_cnt = {16'h0000, count_register};
	wire [31:0] rd_cap = {16'h0000, capture_reload_register};
	wire [31:0] rd_cor = {31'h00000000, global_int_en};
	wire [31:0] rdata  = hit_ctl ? rd_ctl : hit_cnt ? rd_cnt
		: hit_cap ? rd_cap : hit_cor ? rd_cor : 32'h00000000;

	// timer state registers
	always_ff @(posedge mclk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			ctrl           <= tic_ctrl_s'(`TIC_RST_CTRL);
			count_register <= `TIC_RST_CNT;
			dstate         <= TIC_ARM;
		end
		else
		begin
			ctrl           <= next_ctrl;
			count_register <= next_count;
			dstate         <= next_dstate;
		end
	end

	// capture register; a hardware capture beats a software write
	always_ff @(posedge mclk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			capture_reload_register <= `TIC_RST_CNT;
		else if (capt_ev)
			capture_reload_register <= count_register;
		else if (wr_cap)
			capture_reload_register <= cap_wdat;
	end

	// global enable and interrupt output
	always_ff @(posedge mclk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			global_int_en           <= 1'b0;
			timer_interrupt_request <= 1'b0;
		end
		else
		begin
			global_int_en           <= wr_gie ? wb_dat_i[0] : global_int_en;
			timer_interrupt_request <= next_irq;
		end
	end

	// wishbone answer one cycle after the request, dropped after one
	always_ff @(posedge mclk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= (req & ~wb_ack_o) ? rdata : wb_dat_o;
		end
	end

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_s_n);

	sequence s_first;
		first_go && !wr_cnt;
	endsequence
	sequence s_flag_rise;
		pnd_ev && ctrl.mask && global_int_en && !wr_go;
	endsequence

	AST_DOWN_STEP: assert property (
		in_capt && !wr_cnt && !at_zero
		|=> count_register == 16'($past(count_register) - 16'h0001))
		else $error("capture count did not step down");
	AST_CAPT_COPY: assert property (
		capt_ev |=> capture_reload_register == $past(count_register))
		else $error("capture register missed the count");
	AST_IRQ_GATE: assert property (
		timer_interrupt_request |-> $past(ctrl.mask && global_int_en))
		else $error("interrupt without mask and enable");
	AST_IRQ_RAISE: assert property (
		s_flag_rise ##1 !wr_go |=> timer_interrupt_request)
		else $error("pending flag did not raise interrupt");
	AST_BOTH_FLAGS: assert property (
		capt_ev && uf_ev |=> ctrl.pnd && ctrl.run)
		else $error("simultaneous events lost a flag");
	AST_RUN_IGNORED: assert property (
		in_capt && !ctrl.run && !wr_cnt
		|=> count_register != $past(count_register))
		else $error("run bit stopped the capture count");
	AST_EDGE_POL: assert property (
		in_capt && fall && ctrl.edge1 |-> capt_ev)
		else $error("selected falling edge not captured");
	AST_DIFF_START: assert property (
		s_first |=> count_register == 16'h0000 && dstate == TIC_RUN
		##1 (count_register == 16'h0001 || $past(sec_edge || wr_cnt)
			|| dstate != TIC_RUN))
		else $error("difference count did not start");
	AST_DIFF_STOP: assert property (
		sec_go |=> dstate == TIC_ARM
		&& capture_reload_register == $past(count_register))
		else $error("second edge did not store elapsed count");
	AST_PWM_HOLD: assert property (
		in_pwm && !ctrl.run && !wr_cnt |=> $stable(count_register))
		else $error("stopped timer kept counting");
	AST_WRAP: assert property (
		dn_uf && !wr_cnt |=> count_register == 16'hFFFF && ctrl.run)
		else $error("down count did not wrap with flag");

endmodule
`default_nettype wire

// ===== shared/tic_map.svh
// register map, field positions, reset values and constants of the
// input capture timer; assumes byte addresses on a 32-bit wishbone bus
`ifndef TIC_MAP_SVH
`define TIC_MAP_SVH

// register byte offsets
`define TIC_OFS_CTRL   8'h00
`define TIC_OFS_COUNT  8'h04
`define TIC_OFS_CAPT   8'h08
`define TIC_OFS_CORE   8'h0C

// timer control register field positions
`define TIC_B_RUN      0
`define TIC_B_EDGE     1
`define TIC_B_EDGE2    2
`define TIC_B_PND      3
`define TIC_B_MASK     4
`define TIC_B_MODE     5
`define TIC_CTRL_W     7

// reset values and counter constants
`define TIC_RST_CTRL   7'h00
`define TIC_RST_CNT    16'h0000
`define TIC_ALL_ONES   16'hFFFF
`define TIC_ZERO       16'h0000
`define TIC_ONE        16'h0001

`endif

// ===== shared/tic_pkg.sv
// types of the input capture timer: modes, difference states and the
// packed control register; assumes tic_map.svh is on the include path
package tic_pkg;

	// timer operating modes
	typedef enum logic [1:0] {
		TIC_MODE_PWM,
		TIC_MODE_EVENT,
		TIC_MODE_CAPT,
		TIC_MODE_DIFF
	} tic_mode_e;

	// difference capture sequencer
	typedef enum logic {
		TIC_ARM,
		TIC_RUN
	} tic_diff_e;

	// timer control register, bit 0 lowest
	typedef struct packed {
		tic_mode_e mode;
		logic      mask;
		logic      pnd;
		logic      edge2;
		logic      edge1;
		logic      run;
	} tic_ctrl_s;

endpackage

// ===== logic/tic_edge.sv
// transition detector for the capture input pin
// assumes the pin is synchronous to mclk and reset is already synchronised
`timescale 1ns/1ps
`default_nettype none

module tic_edge
	import tic_pkg::*;
(
	input  wire logic mclk,     // timer clock
	input  wire logic rst_s_n,  // synchronised reset, active low
	input  wire logic pin,      // capture input pin level
	output logic      rise,     // pin went low to high this cycle
	output logic      fall      // pin went high to low this cycle
);

	logic pin_q;

	// previous pin level, idles high like a pulled-up input
	always_ff @(posedge mclk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			pin_q <= 1'b1;
		else
			pin_q <= pin;
	end

	// transitions against the previous sample
	assign rise = pin & ~pin_q;
	assign fall = ~pin & pin_q;

endmodule
`default_nettype wire

// ===== dv/tic_src.sv
// external signal source that drives the capture input pin
// assumes its task is called just after a rising mclk edge
`timescale 1ns/1ps
`default_nettype none

module tic_src
	import tic_pkg::*;
(
	input  wire logic mclk,  // timer clock
	output var  logic pin    // capture input pin
);
	// pin idles high, as a pulled-up input would
	initial pin = 1'b1;

	// set a level and keep it for whole clocks, never under one
	task automatic drive(input logic lvl, input int hold);
		pin <= lvl;
		repeat ((hold < 1) ? 1 : hold) @(posedge mclk);
	endtask
endmodule

`default_nettype wire

// ===== dv/tb_tic_top.sv
// self-checking bench for the capture timer, one task per scenario
// assumes tic_map.svh on the include path and tic_src as pin source
`timescale 1ns/1ps
`default_nettype none
`include "tic_map.svh"

module tb_tic_top
	import tic_pkg::*;
;
	logic        mclk;
	logic        rst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  sel;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic        ack;
	logic [31:0] rdat;
	logic        irq;
	logic        pin;
	logic [31:0] q;
	int          miscompares;
	int          samples_checked;

	tic_top uut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
		.capture_input_pin(pin), .wb_ack_o(ack), .wb_dat_o(rdat),
		.timer_interrupt_request(irq));
	tic_src src (.mclk(mclk), .pin(pin));

	// 100 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic end_sim();
		$display("checked %0d miscompared %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask

	// one classic cycle; hold until ack is sampled, then idle a clock
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		sel  <= 4'hF;
		adr  <= a;
		wdat <= d;
		// only the watchdog ends a wait for the answer
		do
			@(posedge mclk);
		while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		wb(1'b0, a, 32'h0, d);
	endtask

	// reset values and an unmapped offset
	task automatic t_reset();
		rd(`TIC_OFS_CTRL, q);
		chk("control after reset", 32'h0, q);
		rd(8'h10, q);
		chk("unmapped read", 32'h0, q);
		chk("irq after reset", 32'h0, {31'h0, irq});
	endtask

	// capture on rising, then switch to falling without leaving the mode
	task automatic t_capt();
		logic [31:0] c1;
		time         t1;
		src.drive(1'b0, 2);
		wr(`TIC_OFS_COUNT, 32'h0000FFFF);
		wr(`TIC_OFS_CTRL, 32'h00000050);
		t1 = $time;
		src.drive(1'b1, 4);
		rd(`TIC_OFS_CTRL, q);
		chk("capture pending", 32'h1, {31'h0, q[3]});
		chk("irq without global enable", 32'h0, {31'h0, irq});
		wr(`TIC_OFS_CORE, 32'h1);
		repeat (2) @(posedge mclk);
		chk("irq with global enable", 32'h1, {31'h0, irq});
		rd(`TIC_OFS_CAPT, c1);
		chk("first capture", 32'h0000FFFE, c1);
		wr(`TIC_OFS_CTRL, 32'h00000050);
		repeat (2) @(posedge mclk);
		chk("irq after clear", 32'h0, {31'h0, irq});
		src.drive(1'b0, 3);
		rd(`TIC_OFS_CTRL, q);
		chk("wrong edge ignored", 32'h0, {31'h0, q[3]});
		wr(`TIC_OFS_CTRL, 32'h00000052);
		src.drive(1'b1, 3);
		rd(`TIC_OFS_CTRL, q);
		chk("rising ignored on falling", 32'h0, {31'h0, q[3]});
		// count seen at the next edge, one step per clock since mode entry
		c1 = {16'h0000, 16'hFFFE - 16'(($time - t1) / 64'd10)};
		src.drive(1'b0, 3);
		chk("irq on second capture", 32'h1, {31'h0, irq});
		rd(`TIC_OFS_CAPT, q);
		chk("falling capture", c1, q);
	endtask

	// wrap from zero in capture mode, then halt by leaving the mode
	task automatic t_wrap();
		logic [31:0] c;
		wr(`TIC_OFS_CTRL, 32'h00000040);
		wr(`TIC_OFS_COUNT, 32'h00000005);
		repeat (10) @(posedge mclk);
		rd(`TIC_OFS_CTRL, q);
		chk("underflow flag", 32'h1, {31'h0, q[0]});
		rd(`TIC_OFS_COUNT, q);
		chk("wrapped count", 32'hFF, {24'h0, q[15:8]});
		// capture edge meets the zero count: both flags in one cycle
		wr(`TIC_OFS_CTRL, 32'h00000040);
		wr(`TIC_OFS_COUNT, 32'h00000001);
		src.drive(1'b1, 2);
		rd(`TIC_OFS_CTRL, q);
		chk("both flags", 32'h3, {30'h0, q[3], q[0]});
		rd(`TIC_OFS_CAPT, q);
		chk("capture at zero", 32'h0, q);
		wr(`TIC_OFS_CTRL, 32'h0);
		rd(`TIC_OFS_COUNT, c);
		repeat (5) @(posedge mclk);
		rd(`TIC_OFS_COUNT, q);
		chk("halted count", c, q);
	endtask

	// every edge pairing of difference capture
	task automatic t_diff();
		logic e1;
		logic e2;
		int   d;
		for (int p = 0; p < 4; p++)
		begin
			e1 = p[1];
			e2 = p[0];
			d = (e1 == e2) ? 8 : 4;
			wr(`TIC_OFS_CTRL, 32'h0);
			src.drive(e1, 2);
			wr(`TIC_OFS_CTRL, {25'h0, 2'b11, 2'b00, e2, e1, 1'b0});
			src.drive(~e1, 4);
			if (e1 == e2)
				src.drive(e2, 4);
			src.drive(~e2, 4);
			rd(`TIC_OFS_CAPT, q);
			chk("difference count", 32'(d - 1), q);
			rd(`TIC_OFS_CTRL, q);
			chk("difference pending", 32'h1, {31'h0, q[3]});
		end
	endtask

	// main sequence
	initial
	begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'hF;
		adr = 8'h00;
		wdat = 32'h0;
		miscompares = 0;
		samples_checked = 0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_capt();
		t_wrap();
		t_diff();
		end_sim();
	end

	// cut a hang short
	initial
	begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		end_sim();
	end
endmodule

`default_nettype wire
